//--- rtl/flash_host_ctrl.v
// Host controller issuing command sequences to a parallel flash device
// Assumes the flash pins are driven directly and the supply switch is external
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_host_ctrl (
  input  wire                 ref_clk_in,
  input  wire                 rstn_in,
  input  wire                 op_valid_in,
  input  wire [2:0]           op_code_in,
  input  wire [`ADDR_W-1:0]   op_addr_in,
  input  wire [`DATA_W-1:0]   op_data_in,
  input  wire                 supply_ok_in,
  input  wire [`DATA_W-1:0]   flash_data_in,
  output reg                  op_ready_out,
  output reg                  op_done_out,
  output reg                  op_error_out,
  output reg  [`DATA_W-1:0]   op_result_out,
  output reg                  supply_on_out,
  output reg  [`ADDR_W-1:0]   flash_addr_out,
  output reg  [`DATA_W-1:0]   flash_data_out,
  output wire                 flash_data_oe_n_out,
  output wire                 flash_cs_n_out,
  output wire                 flash_oe_n_out,
  output wire                 flash_we_n_out
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_CMD1  = 3'h1;
  localparam ST_CMD2  = 3'h2;
  localparam ST_POLL  = 3'h3;
  localparam ST_CHECK = 3'h4;
  localparam ST_READ  = 3'h5;
  localparam ST_WAIT  = 3'h6;
  reg  [2:0]          state;
  reg  [2:0]          return_state;
  reg  [2:0]          op;
  reg  [`DATA_W-1:0]  want;
  reg  [23:0]         poll_count;
  reg                 supply_meta;
  reg                 supply_sync;
  reg  [`DATA_W-1:0]  data_meta;
  reg  [`DATA_W-1:0]  data_sync;
  reg                 cyc_start;
  reg                 cyc_write;
  wire                cyc_busy;
  wire                cyc_done;
  wire [`DATA_W-1:0]  cyc_byte;
  // ----------------------------------------
  // Completion test on the status bit
  // ----------------------------------------
  function status_done;
    input [2:0]         kind;
    input [`DATA_W-1:0] rd;
    input [`DATA_W-1:0] wr;
    begin
      if (kind == `OP_ERASE)
        status_done = rd[`STATUS_BIT];
      else
        status_done = (rd[`STATUS_BIT] == wr[`STATUS_BIT]);
    end
  endfunction
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
      data_meta   <= 8'h00;
      data_sync   <= 8'h00;
    end
    else
    begin
      supply_meta <= supply_ok_in;
      supply_sync <= supply_meta;
      data_meta   <= flash_data_in;
      data_sync   <= data_meta;
    end
  end
  flash_bus_cycle u_cycle (
    .ref_clk_in      (ref_clk_in),
    .rstn_in         (rstn_in),
    .start_in        (cyc_start),
    .write_in        (cyc_write),
    .pin_data_in     (data_sync),
    .busy_out        (cyc_busy),
    .done_out        (cyc_done),
    .read_byte_out   (cyc_byte),
    .chip_sel_n_out  (flash_cs_n_out),
    .out_en_n_out    (flash_oe_n_out),
    .wr_strobe_n_out (flash_we_n_out),
    .data_oe_n_out   (flash_data_oe_n_out)
  );
  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state          <= ST_IDLE;
      return_state   <= ST_IDLE;
      op             <= `OP_READ;
      want           <= 8'h00;
      poll_count     <= 24'h000000;
      cyc_start      <= 1'b0;
      cyc_write      <= 1'b0;
      op_ready_out   <= 1'b0;
      op_done_out    <= 1'b0;
      op_error_out   <= 1'b0;
      op_result_out  <= 8'h00;
      supply_on_out  <= 1'b0;
      flash_addr_out <= 18'h00000;
      flash_data_out <= 8'h00;
    end
    else
    begin
      cyc_start   <= 1'b0;
      op_done_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          op_ready_out <= 1'b1;
          if (op_valid_in)
          begin
            op_ready_out   <= 1'b0;
            op_error_out   <= 1'b0;
            op             <= op_code_in;
            want           <= op_data_in;
            flash_addr_out <= op_addr_in;
            // Erase, program and identify need the high supply; read and reset do not
            supply_on_out  <= (op_code_in == `OP_ERASE) || (op_code_in == `OP_PROGRAM) ||
                              (op_code_in == `OP_IDENT);
            state          <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (!supply_on_out || supply_sync)
          begin
            cyc_start <= 1'b1;
            cyc_write <= 1'b1;
            state     <= ST_CMD1;
            case (op)
              `OP_READ:    flash_data_out <= `CMD_READ;
              `OP_IDENT:   flash_data_out <= `CMD_IDENT;
              `OP_ERASE:   flash_data_out <= `CMD_ERASE;
              `OP_PROGRAM: flash_data_out <= `CMD_PROGRAM;
              default:     flash_data_out <= `CMD_READ_ALT;
            endcase
          end
        end
        ST_CMD1:
        begin
          if (cyc_done)
          begin
            state <= ST_CMD2;
            if (op == `OP_ERASE)
            begin
              // No pre-program pass before erase
              cyc_start      <= 1'b1;
              flash_data_out <= `CMD_ERASE;
            end
            else if (op == `OP_PROGRAM)
            begin
              cyc_start      <= 1'b1;
              flash_data_out <= want;
            end
            else if (op == `OP_RESET)
            begin
              // Second reset covers a pending program setup
              cyc_start      <= 1'b1;
              flash_data_out <= `CMD_READ_ALT;
            end
            else
            begin
              cyc_write <= 1'b0;
              cyc_start <= 1'b1;
              if (op == `OP_IDENT)
                flash_addr_out <= `ID_MAKER_ADDR;
            end
          end
        end
        ST_CMD2:
        begin
          if (cyc_done)
          begin
            poll_count <= 24'h000000;
            if (op == `OP_ERASE || op == `OP_PROGRAM)
            begin
              cyc_write <= 1'b0;
              cyc_start <= 1'b1;
              state     <= ST_POLL;
            end
            else if (op == `OP_IDENT)
            begin
              op_result_out  <= cyc_byte;
              flash_addr_out <= `ID_PART_ADDR;
              cyc_start      <= 1'b1;
              state          <= ST_READ;
            end
            else
            begin
              op_result_out <= cyc_byte;
              return_state  <= ST_IDLE;
              state         <= ST_READ;
            end
          end
        end
        ST_POLL:
        begin
          if (cyc_done)
          begin
            poll_count <= poll_count + 24'h000001;
            // Poll until completion or until poll_count reaches POLL_LIMIT
            if (status_done(op, cyc_byte, want))
            begin
              supply_on_out <= 1'b0;
              if (op == `OP_ERASE)
              begin
                cyc_start <= 1'b1;
                state     <= ST_CHECK;
              end
              else
              begin
                op_result_out <= cyc_byte;
                state         <= ST_READ;
              end
            end
            else if (poll_count == `POLL_LIMIT)
            begin
              op_error_out  <= 1'b1;
              supply_on_out <= 1'b0;
              state         <= ST_READ;
            end
            else
              cyc_start <= 1'b1;
          end
        end
        ST_CHECK:
        begin
          if (cyc_done)
          begin
            op_result_out <= cyc_byte;
            op_error_out  <= (cyc_byte != `ERASED_BYTE);
            state         <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (!cyc_busy && !cyc_start)
          begin
            if (op == `OP_IDENT && flash_addr_out == `ID_PART_ADDR && !op_done_out)
            begin
              flash_addr_out <= `ID_MAKER_ADDR;
              op_result_out  <= cyc_byte;
            end
            op_done_out   <= 1'b1;
            op_ready_out  <= 1'b1;
            supply_on_out <= 1'b0;
            state         <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // flash_host_ctrl

//--- rtl/flash_host_defines.vh
// Constants for the parallel flash host controller
// Assumes a 10 MHz reference clock and a byte-wide flash device
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
`define ADDR_W            18
`define DATA_W            8
`define CMD_READ          8'h00
`define CMD_READ_ALT      8'hff
`define CMD_IDENT         8'h90
`define CMD_ERASE         8'h30
`define CMD_PROGRAM       8'h50
`define ID_MAKER_ADDR     18'h00000
`define ID_PART_ADDR      18'h00001
`define ERASED_BYTE       8'hff
`define STATUS_BIT        7
`define PHASE_LAST        2'h3
`define POLL_LIMIT        24'hffffff
`define OP_READ           3'h0
`define OP_IDENT          3'h1
`define OP_ERASE          3'h2
`define OP_PROGRAM        3'h3
`define OP_RESET          3'h4
`endif

//--- rtl/flash_bus_cycle.v
// Single asynchronous bus cycle generator for the flash pins
// Assumes the caller holds address and data stable while busy is high
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_bus_cycle (
  input  wire                 ref_clk_in,
  input  wire                 rstn_in,
  input  wire                 start_in,
  input  wire                 write_in,
  input  wire [`DATA_W-1:0]   pin_data_in,
  output reg                  busy_out,
  output reg                  done_out,
  output reg  [`DATA_W-1:0]   read_byte_out,
  output reg                  chip_sel_n_out,
  output reg                  out_en_n_out,
  output reg                  wr_strobe_n_out,
  output reg                  data_oe_n_out
);
  reg [1:0] phase;
  reg       is_write;
  // ----------------------------------------
  // Cycle phases: select, strobe, hold, release
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      phase           <= 2'h0;
      is_write        <= 1'b0;
      busy_out        <= 1'b0;
      done_out        <= 1'b0;
      read_byte_out   <= 8'h00;
      chip_sel_n_out  <= 1'b1;
      out_en_n_out    <= 1'b1;
      wr_strobe_n_out <= 1'b1;
      data_oe_n_out   <= 1'b1;
    end
    else
    begin
      done_out <= 1'b0;
      if (!busy_out)
      begin
        if (start_in)
        begin
          busy_out       <= 1'b1;
          is_write       <= write_in;
          phase          <= 2'h0;
          chip_sel_n_out <= 1'b0;
          data_oe_n_out  <= ~write_in;
        end
      end
      else
      begin
        phase <= phase + 2'h1;
        case (phase)
          2'h0:
          begin
            // Strobe falls after select: address taken on later fall
            if (is_write)
              wr_strobe_n_out <= 1'b0;
            else
              out_en_n_out <= 1'b0;
          end
          2'h2:
          begin
            // Strobe rises before select: data taken on earlier rise
            wr_strobe_n_out <= 1'b1;
            out_en_n_out    <= 1'b1;
          end
          `PHASE_LAST:
          begin
            // Pin data lags two sync stages, so take it here
            if (!is_write)
              read_byte_out <= pin_data_in;
            chip_sel_n_out <= 1'b1;
            data_oe_n_out  <= 1'b1;
            busy_out       <= 1'b0;
            done_out       <= 1'b1;
          end
          default:
          begin
          end
        endcase
      end
    end
  end
endmodule // flash_bus_cycle

//--- verification/flash_dev_model.sv
// Behavioural byte-wide flash device on the far side of the host controller
// Assumes active-low strobes; only address bits 7:0 are stored
`timescale 1ns/1ps
module flash_dev_model #(
  parameter [7:0] MAKER_CODE = 8'h5c,  // Arbitrary value
  parameter [7:0] PART_CODE  = 8'ha3,  // Arbitrary value
  parameter       ERASE_NS   = 3000,
  parameter       PROG_NS    = 1500
) (
  input  wire        supply_in,
  input  wire        cs_n_in,
  input  wire        oe_n_in,
  input  wire        we_n_in,
  input  wire [17:0] addr_in,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out
);
  // ----
  // Command state and array
  // ----
  reg [7:0]  mem [0:255];
  reg [7:0]  prog_val, rv, last;
  reg [17:0] lat_addr;
  reg [1:0]  mode;
  reg        wr_on, busy_e, busy_p;
  integer    i;
  event      go_e, go_p;
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5a;
    {mode, wr_on, busy_e, busy_p, last, prog_val, lat_addr} = 0;
  end
  always @(negedge we_n_in or negedge cs_n_in)
    if (!we_n_in && !cs_n_in && oe_n_in)
    begin
      wr_on = 1'b1;
      lat_addr = addr_in;
    end
  always @(posedge we_n_in or posedge cs_n_in)
    if (wr_on)
    begin
      wr_on = 1'b0;
      if (!supply_in)
        mode = 2'h0;
      else if (!busy_e && !busy_p)
        case (mode)
          2'h3:
          begin
            mode = 2'h0;
            prog_val = data_in;
            if (data_in != 8'hff)
              -> go_p;
          end
          2'h2:
          begin
            mode = 2'h0;
            if (data_in == 8'h30)
              -> go_e;
          end
          default:
            mode = (data_in == 8'h30) ? 2'h2 :
                   (data_in == 8'h10 || data_in == 8'h50) ? 2'h3 :
                   (data_in == 8'h80 || data_in == 8'h90) ? 2'h1 : 2'h0;
        endcase
    end
  always @(go_e)
  begin
    busy_e = 1'b1;
    #(ERASE_NS / 2);
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'h00;
    #(ERASE_NS / 2);
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'hff;
    busy_e = 1'b0;
  end
  always @(go_p)
  begin
    busy_p = 1'b1;
    #(PROG_NS);
    mem[lat_addr[7:0]] = mem[lat_addr[7:0]] & prog_val;
    busy_p = 1'b0;
  end
  always @*
    if (busy_e)
      rv = 8'h00;
    else if (busy_p)
      rv = {~prog_val[7], 7'h00};
    else if (mode == 2'h1)
      rv = (addr_in == 18'h0) ? MAKER_CODE : PART_CODE;
    else
      rv = mem[addr_in[7:0]];
  always @(rv or cs_n_in or oe_n_in)
    if (!cs_n_in && !oe_n_in)
    begin
      data_out = rv;
      last = rv;
    end
    else
      data_out = ~last;
endmodule // flash_dev_model

//--- verification/flash_host_ctrl_sva.sv
// Checker on the flash host controller pins
// Assumes one clock domain and active-low strobes
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_host_ctrl_sva (
  input wire                ref_clk_in,
  input wire                rstn_in,
  input wire                op_ready_out,
  input wire                op_done_out,
  input wire [`ADDR_W-1:0]  flash_addr_out,
  input wire [`DATA_W-1:0]  flash_data_out,
  input wire                flash_data_oe_n_out,
  input wire                flash_cs_n_out,
  input wire                flash_oe_n_out,
  input wire                flash_we_n_out
);
  // ----
  // Pin relations
  // ----
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_we_sel; !flash_we_n_out |-> !flash_cs_n_out && flash_oe_n_out; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write without select");
  property p_addr_hold; !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_data_hold; !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_drive; !flash_we_n_out |-> !flash_data_oe_n_out; endproperty
  a_drive: assert property (p_drive) else $error("data not driven");
  property p_no_fight; !flash_oe_n_out |-> flash_data_oe_n_out && flash_we_n_out; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus contention");
  property p_strobe_end; $fell(flash_we_n_out) |-> ##[1:4] flash_we_n_out; endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe stuck low");
  property p_done; op_done_out |=> !op_done_out; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_idle; op_ready_out |-> flash_we_n_out && flash_oe_n_out; endproperty
  a_idle: assert property (p_idle) else $error("strobe in idle");
endmodule // flash_host_ctrl_sva
bind flash_host_ctrl flash_host_ctrl_sva u_flash_host_ctrl_sva (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .op_ready_out(op_ready_out),
  .op_done_out(op_done_out), .flash_addr_out(flash_addr_out),
  .flash_data_out(flash_data_out), .flash_data_oe_n_out(flash_data_oe_n_out),
  .flash_cs_n_out(flash_cs_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_we_n_out(flash_we_n_out));

//--- verification/flash_host_ctrl_tb.sv
// Testbench for the flash host controller
// Assumes the device model above with its supply following the controller's request
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_host_ctrl_tb;
  // ----
  // Stimulus and wiring
  // ----
  localparam [7:0]         PART = 8'ha3;  // Arbitrary value
  reg                      ref_clk_in = 1'b0;
  reg                      rstn_in = 1'b0;
  reg                      op_valid_in = 1'b0;
  reg                      supply_ok_in = 1'b0;
  reg  [2:0]               op_code_in = 3'h0;
  reg  [`ADDR_W-1:0]       op_addr_in = 18'h00000;
  reg  [`DATA_W-1:0]       op_data_in = 8'h00;
  wire [`DATA_W-1:0]       op_result_out, flash_data_out, dev_data, flash_data_in;
  wire [`ADDR_W-1:0]       flash_addr_out;
  wire                     op_ready_out, op_done_out, op_error_out, supply_on_out;
  wire                     flash_data_oe_n_out, flash_cs_n_out, flash_oe_n_out, flash_we_n_out;
  integer                  miscompares = 0;
  integer                  comparisons = 0;
  assign flash_data_in = flash_data_oe_n_out ? dev_data : flash_data_out;
  always #50 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) supply_ok_in <= supply_on_out;
  flash_host_ctrl u_flash_host_ctrl (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_addr_in(op_addr_in),
    .op_data_in(op_data_in), .supply_ok_in(supply_ok_in), .flash_data_in(flash_data_in),
    .op_ready_out(op_ready_out), .op_done_out(op_done_out), .op_error_out(op_error_out),
    .op_result_out(op_result_out), .supply_on_out(supply_on_out),
    .flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
    .flash_data_oe_n_out(flash_data_oe_n_out), .flash_cs_n_out(flash_cs_n_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out));
  flash_dev_model #(.PART_CODE(PART)) u_flash_dev_model (.supply_in(supply_ok_in),
    .cs_n_in(flash_cs_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
    .addr_in(flash_addr_out), .data_in(flash_data_out), .data_out(dev_data));
  task close_out;
    begin
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp, input [8*12-1:0] msg);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("ERROR %0t %0s", $time, msg);
      end
    end
  endtask
  task do_op(input [2:0] c, input [`ADDR_W-1:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      while (op_ready_out !== 1'b1 && n < 50)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      op_code_in = c;
      op_addr_in = a;
      op_data_in = d;
      op_valid_in = 1'b1;
      @(negedge ref_clk_in);
      op_valid_in = 1'b0;
      while (op_done_out !== 1'b1 && n < 9000)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      check({7'h00, op_error_out}, {7'h00, n >= 9000}, "no timeout");
      check({7'h00, supply_on_out}, 8'h00, "supply off");
      if (n >= 9000)
        close_out;
    end
  endtask
  task rd_chk(input [`ADDR_W-1:0] a, input [7:0] exp);
    begin
      do_op(`OP_READ, a, 8'h00);
      check(op_result_out, exp, "read byte");
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_read;
    begin
      rd_chk(18'h00005, 8'h5f);
      rd_chk(18'h00080, 8'hda);
    end
  endtask
  task t_ident;
    begin
      do_op(`OP_IDENT, 18'h00000, 8'h00);
      check(op_result_out, PART, "part code");
      rd_chk(18'h00001, 8'h5b);
    end
  endtask
  task t_erase;
    begin
      do_op(`OP_ERASE, 18'h00000, 8'h00);
      check(op_result_out, `ERASED_BYTE, "erased byte");
      rd_chk(18'h00007, 8'hff);
    end
  endtask
  task t_program;
    begin
      do_op(`OP_PROGRAM, 18'h00003, 8'h12);
      do_op(`OP_PROGRAM, 18'h00009, 8'h81);
      rd_chk(18'h00003, 8'h12);
      rd_chk(18'h00009, 8'h81);
    end
  endtask
  task t_reset;
    begin
      do_op(`OP_RESET, 18'h00000, 8'h00);
      rd_chk(18'h00003, 8'h12);
      rd_chk(18'h00004, 8'hff);
    end
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    @(negedge ref_clk_in);
    t_read;
    t_ident;
    t_erase;
    t_program;
    t_reset;
    close_out;
  end
endmodule // flash_host_ctrl_tb
